//--- verilog/serial_port_pkg.sv
// constants, enumerations and carriers for the four-mode serial port
package serial_port_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////
   // register addresses on the special function register bus
   localparam logic [7:0] ADDR_POWER_AND_BAUD_DOUBLE_CONTROL = 8'h87;
   localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
   localparam logic [7:0] ADDR_SERIAL_DATA_BUFFER = 8'h99;
   localparam logic [7:0] ADDR_CONFIGURATION = 8'haf;

   // serial_control fields
   localparam int SC_MODE_SELECT_HIGH = 7;
   localparam int SC_MODE_SELECT_LOW = 6;
   localparam int SC_FRAME_OR_MULTIPROC_CHECK = 5;
   localparam int SC_RECEIVE_ENABLE = 4;
   localparam int SC_TRANSMIT_NINTH_BIT = 3;
   localparam int SC_RECEIVED_NINTH_BIT = 2;
   localparam int SC_TRANSMIT_FLAG = 1;
   localparam int SC_RECEIVE_FLAG = 0;
   // power_and_baud_double_control and configuration fields
   localparam int PC_BAUD_DOUBLE_BIT = 7;
   localparam int CFG_EXTENDED_UART_ENABLE = 5;

   // values after reset
   localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] CONFIGURATION_RESET = 8'h00;
   localparam logic [7:0] DATA_BUFFER_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////////////
   // timing counts in core clock cycles, oversampling ticks and bits
   localparam logic [3:0] SHIFT_PERIOD_LAST = 4'hb;   // mode 0 bit lasts 12 cycles
   localparam logic [3:0] SHIFT_CLOCK_HIGH = 4'h6;    // shift clock rises at phase 6
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;     // 16 ticks per bit
   localparam logic [3:0] OVERSAMPLE_MID = 4'h7;      // start bit checked at mid-bit
   localparam logic [3:0] SHIFT_BITS_LAST = 4'h7;     // eight bits in mode 0
   localparam logic [3:0] RX_BITS_LAST = 4'h8;        // eight data bits plus ninth
   localparam logic [3:0] FRAME_BITS_8 = 4'ha;        // 10-bit frame
   localparam logic [3:0] FRAME_BITS_9 = 4'hb;        // 11-bit frame

   ////////////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00,
      MODE_UART8 = 2'b01,
      MODE_UART9_FIXED = 2'b10,
      MODE_UART9_VAR = 2'b11
   } mode_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_SHIFT = 2'b10,
      TX_SYNC = 2'b11
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_SYNC = 2'b11
   } rx_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic t1_ovf;
      logic t2_tx_ovf;
      logic t2_rx_ovf;
      logic t2_tx_sel;
      logic t2_rx_sel;
      logic uart_timer_tick;
   } baud_src_t;

endpackage

//--- verilog/serial_port.sv
// four-mode serial port with transmit fifo
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////////////////
module tx_word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } fifo_state_t;

   fifo_state_t s;
   fifo_state_t next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready = s.count != (AW+1)'(DEPTH);
   assign out_valid = s.count != '0;
   assign out_data = mem[s.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.wr_ptr = (s.wr_ptr == AW'(DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
      end
      if (pop) begin
         next_s.rd_ptr = (s.rd_ptr == AW'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_s.count = s.count + 1'b1;
      end else if (pop && !push) begin
         next_s.count = s.count - 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[s.wr_ptr] <= in_data;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// (R1) mode bits: 00 shift, 01 8-bit uart, 10 9-bit fixed, 11 9-bit variable
// (R2) mode 0 moves data on receive pin, shift clock on transmit pin, core/12
// (R3) mode 0 transmit sends eight bits least significant first
// (R4) mode 0 receive starts only with receive enable set and receive flag clear
// (R5) mode 1 frame: start zero, eight data bits lsb first, stop one
// (R6) modes 1 and 3 take rate from timer 1, timer 2 or baud timer
// (R7) mode 1 loads stop one as ninth, transmit flag set when stop appears
// (R8) mode 1 receive begins on falling edge, needs confirmed start bit
// (R9) without extended uart a character is taken only if receive flag clear
// (R10) mode 1 with check bit set needs received stop bit one
// (R11) failed acceptance drops the frame, receive flag untouched
// (R12) accepted mode 1 frame: data to buffer, stop to ninth field, flag set
// (R13) mode 2 frame: start, eight data, programmable ninth, stop
// (R14) 9-bit transmit takes ninth from control, starts on next baud tick
// (R15) 9-bit modes with check bit accept only ninth bit one
// (R16) accepted 9-bit frame: data to buffer, ninth to field, flag set
// (R17) mode 2 runs at core/32, or core/16 with double-rate bit
// (R18) mode 3 equals mode 2 except rate from selected timer
// (R19) any write to the data buffer starts a transmission; writes queue in the fifo, one made while it is full is lost
// (R20) async reception starts on start bit only with receive enable set
// (R21) timer 1 rate is 2^double over 32 times overflow rate
// (R22) software keeps timer 1 interrupt off and uses autoreload
// (R23) extended uart accepts even with receive flag set; overwrite flag set, buffer read clears it
// (R24) baud timer enable selects fractional timer, ignores double and timer 2 selects
// (R25) receiver oversamples 16x, checks start mid-bit, samples bit centres
// (R26) software clears transmit and receive flags; hardware only sets them
module serial_port
   import serial_port_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // special function register access
   input wire sfr_req_t sfr,
   output logic [7:0] sfr_rdata,
   output logic tx_ready,
   // baud sources
   input wire baud_src_t baud,
   input wire logic dedicated_baud_timer_enable,
   // serial pins
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   output logic txd,
   // status
   output logic overwrite_error
);
   typedef struct packed {
      logic [7:0] serial_control;
      logic [7:0] power_and_baud_double_control;
      logic [7:0] cfg;
      logic [7:0] rx_buf;
      logic [7:0] rdata;
      logic ovr;
      logic rxd_prev;
      logic t1_half;
      logic m2_half;
      tx_state_t tx_state;
      logic [10:0] tx_shift;
      logic [3:0] tx_bits;
      logic [3:0] tx_sub;
      logic [3:0] tx_total;
      rx_state_t rx_state;
      logic [8:0] rx_shift;
      logic [3:0] rx_bits;
      logic [3:0] rx_sub;
      logic txd;
      logic rxd_out;
      logic rxd_oe;
   } port_state_t;

   port_state_t s;
   port_state_t next_s;
   mode_t mode;
   logic baud_double_bit;
   logic extended_uart_enable;
   logic sm2;
   logic ren;
   logic ri;
   logic t1_tick;
   logic m2_tick;
   logic tx_tick;
   logic rx_tick;
   logic buf_wr;
   logic fifo_valid;
   logic fifo_pop;
   logic [8:0] fifo_q;
   logic rx_final;
   logic rx_accept;
   logic sync_done;

   assign mode = mode_t'({s.serial_control[SC_MODE_SELECT_HIGH], s.serial_control[SC_MODE_SELECT_LOW]}); // see (R1)
   assign baud_double_bit = s.power_and_baud_double_control[PC_BAUD_DOUBLE_BIT];
   assign extended_uart_enable = s.cfg[CFG_EXTENDED_UART_ENABLE];
   assign sm2 = s.serial_control[SC_FRAME_OR_MULTIPROC_CHECK];
   assign ren = s.serial_control[SC_RECEIVE_ENABLE];
   assign ri = s.serial_control[SC_RECEIVE_FLAG];

   ////////////////////////////////////////////////////////////////////////////////////////
   // 16x oversampling ticks
   assign t1_tick = baud.t1_ovf && (baud_double_bit || s.t1_half); // see (R21)
   assign m2_tick = baud_double_bit || s.m2_half; // see (R17)
   always_comb begin
      if (mode == MODE_UART9_FIXED) begin
         tx_tick = m2_tick;
         rx_tick = m2_tick;
      end else if (dedicated_baud_timer_enable) begin // see (R24)
         tx_tick = baud.uart_timer_tick;
         rx_tick = baud.uart_timer_tick;
      end else begin // see (R6) (R18)
         tx_tick = baud.t2_tx_sel ? baud.t2_tx_ovf : t1_tick;
         rx_tick = baud.t2_rx_sel ? baud.t2_rx_ovf : t1_tick;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // transmit buffer
   assign buf_wr = sfr.wr && sfr.addr == ADDR_SERIAL_DATA_BUFFER; // see (R19)
   assign fifo_pop = s.tx_state == TX_IDLE && fifo_valid
                     && !(mode == MODE_SHIFT && s.rx_state == RX_SYNC);

   tx_word_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .in_valid(buf_wr),
      .in_ready(tx_ready),
      .in_data({s.serial_control[SC_TRANSMIT_NINTH_BIT], sfr.wdata}), // see (R14)
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_q)
   );

   assign rx_final = s.rx_state == RX_DATA && rx_tick && s.rx_sub == OVERSAMPLE_LAST
                     && s.rx_bits == RX_BITS_LAST;
   assign rx_accept = (extended_uart_enable || !ri) && (!sm2 || rxd_in); // see (R9) (R10) (R15)
   assign sync_done = s.rx_state == RX_SYNC && s.rx_sub == SHIFT_PERIOD_LAST
                      && s.rx_bits == SHIFT_BITS_LAST;

   ////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;
      next_s.rxd_prev = rxd_in;
      if (baud.t1_ovf) begin
         next_s.t1_half = !s.t1_half;
      end
      next_s.m2_half = !s.m2_half;
      // register writes; hardware sets below win over them
      if (sfr.wr) begin
         case (sfr.addr)
            ADDR_POWER_AND_BAUD_DOUBLE_CONTROL: next_s.power_and_baud_double_control = sfr.wdata;
            ADDR_SERIAL_CONTROL: next_s.serial_control = sfr.wdata; // see (R26)
            ADDR_CONFIGURATION: next_s.cfg = sfr.wdata;
            default: next_s.cfg = s.cfg;
         endcase
      end
      if (sfr.rd) begin
         case (sfr.addr)
            ADDR_POWER_AND_BAUD_DOUBLE_CONTROL: next_s.rdata = s.power_and_baud_double_control;
            ADDR_SERIAL_CONTROL: next_s.rdata = s.serial_control;
            ADDR_SERIAL_DATA_BUFFER: next_s.rdata = s.rx_buf;
            ADDR_CONFIGURATION: next_s.rdata = s.cfg;
            default: next_s.rdata = 8'h00;
         endcase
         if (sfr.addr == ADDR_SERIAL_DATA_BUFFER) begin
            next_s.ovr = 1'b0; // see (R23)
         end
      end

      // transmitter
      case (s.tx_state)
         TX_IDLE: begin
            next_s.txd = 1'b1;
            if (fifo_pop) begin
               next_s.tx_bits = 4'h0;
               next_s.tx_sub = 4'h0;
               if (mode == MODE_SHIFT) begin
                  next_s.tx_shift = {3'b111, fifo_q[7:0]}; // see (R3)
                  next_s.tx_state = TX_SYNC;
                  next_s.txd = 1'b0;
               end else begin
                  // stop one sits above the ninth position
                  next_s.tx_shift = {1'b1, (mode == MODE_UART8) ? 1'b1 : fifo_q[8],
                                     fifo_q[7:0], 1'b0}; // see (R5) (R7) (R13) (R14)
                  next_s.tx_total = (mode == MODE_UART8) ? FRAME_BITS_8 : FRAME_BITS_9;
                  next_s.tx_state = TX_WAIT;
               end
            end
         end
         TX_WAIT: begin
            if (tx_tick) begin // see (R14)
               next_s.tx_state = TX_SHIFT;
               next_s.txd = s.tx_shift[0];
            end
         end
         TX_SHIFT: begin
            if (tx_tick) begin
               next_s.tx_sub = s.tx_sub + 4'h1;
               if (s.tx_sub == OVERSAMPLE_LAST) begin
                  next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
                  next_s.tx_bits = s.tx_bits + 4'h1;
                  next_s.txd = s.tx_shift[1];
                  if (s.tx_bits + 4'h1 == s.tx_total - 4'h1) begin
                     next_s.serial_control[SC_TRANSMIT_FLAG] = 1'b1; // see (R7) (R14)
                  end
                  if (s.tx_bits + 4'h1 == s.tx_total) begin
                     next_s.tx_state = TX_IDLE;
                     next_s.txd = 1'b1;
                  end
               end
            end
         end
         TX_SYNC: begin // see (R2)
            next_s.tx_sub = (s.tx_sub == SHIFT_PERIOD_LAST) ? 4'h0 : s.tx_sub + 4'h1;
            next_s.txd = next_s.tx_sub >= SHIFT_CLOCK_HIGH;
            if (s.tx_sub == SHIFT_PERIOD_LAST) begin
               next_s.tx_shift = {1'b1, s.tx_shift[10:1]};
               next_s.tx_bits = s.tx_bits + 4'h1;
               if (s.tx_bits == SHIFT_BITS_LAST) begin
                  next_s.tx_state = TX_IDLE;
                  next_s.txd = 1'b1;
                  next_s.serial_control[SC_TRANSMIT_FLAG] = 1'b1;
               end
            end
         end
         default: next_s.tx_state = TX_IDLE;
      endcase

      // receiver
      case (s.rx_state)
         RX_IDLE: begin
            if (mode == MODE_SHIFT) begin
               if (ren && !ri && s.tx_state == TX_IDLE && !fifo_pop) begin // see (R4)
                  next_s.rx_state = RX_SYNC;
                  next_s.rx_sub = 4'h0;
                  next_s.rx_bits = 4'h0;
                  next_s.txd = 1'b0;
               end
            end else if (ren && s.rxd_prev && !rxd_in) begin // see (R8) (R20)
               next_s.rx_state = RX_START;
               next_s.rx_sub = 4'h0;
            end
         end
         RX_START: begin
            if (rx_tick) begin
               next_s.rx_sub = s.rx_sub + 4'h1;
               if (s.rx_sub == OVERSAMPLE_MID) begin // see (R8) (R25)
                  next_s.rx_state = rxd_in ? RX_IDLE : RX_DATA;
                  next_s.rx_sub = 4'h0;
                  next_s.rx_bits = 4'h0;
               end
            end
         end
         RX_DATA: begin
            if (rx_tick) begin
               next_s.rx_sub = s.rx_sub + 4'h1;
               if (s.rx_sub == OVERSAMPLE_LAST) begin // see (R25)
                  next_s.rx_shift = {rxd_in, s.rx_shift[8:1]};
                  next_s.rx_bits = s.rx_bits + 4'h1;
               end
               if (rx_final) begin
                  next_s.rx_state = RX_IDLE;
                  if (rx_accept) begin // see (R11)
                     next_s.rx_buf = s.rx_shift[8:1]; // see (R12) (R16)
                     next_s.serial_control[SC_RECEIVED_NINTH_BIT] = rxd_in;
                     next_s.serial_control[SC_RECEIVE_FLAG] = 1'b1;
                     if (ri) begin
                        next_s.ovr = 1'b1; // see (R23)
                     end
                  end
               end
            end
         end
         RX_SYNC: begin // see (R2)
            next_s.rx_sub = (s.rx_sub == SHIFT_PERIOD_LAST) ? 4'h0 : s.rx_sub + 4'h1;
            next_s.txd = next_s.rx_sub >= SHIFT_CLOCK_HIGH;
            if (s.rx_sub == SHIFT_CLOCK_HIGH) begin
               next_s.rx_shift = {rxd_in, s.rx_shift[8:1]};
            end
            if (s.rx_sub == SHIFT_PERIOD_LAST) begin
               next_s.rx_bits = s.rx_bits + 4'h1;
            end
            if (sync_done) begin
               next_s.rx_state = RX_IDLE;
               next_s.txd = 1'b1;
               next_s.rx_buf = s.rx_shift[8:1];
               next_s.serial_control[SC_RECEIVE_FLAG] = 1'b1;
            end
         end
         default: next_s.rx_state = RX_IDLE;
      endcase

      next_s.rxd_oe = next_s.tx_state == TX_SYNC;
      next_s.rxd_out = (next_s.tx_state == TX_SYNC) ? next_s.tx_shift[0] : 1'b1; // see (R3)
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s <= '0;
         s.serial_control <= SERIAL_CONTROL_RESET;
         s.power_and_baud_double_control <= POWER_CONTROL_RESET;
         s.cfg <= CONFIGURATION_RESET;
         s.rx_buf <= DATA_BUFFER_RESET;
         s.rxd_prev <= 1'b1;
         s.txd <= 1'b1;
         s.rxd_out <= 1'b1;
         s.tx_state <= TX_IDLE;
         s.rx_state <= RX_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign sfr_rdata = s.rdata;
   assign txd = s.txd;
   assign rxd_out = s.rxd_out;
   assign rxd_oe = s.rxd_oe;
   assign overwrite_error = s.ovr;

   ////////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   AST_MODE0_DRIVES_PIN: assert property ( // see (R2)
      s.tx_state == TX_SYNC |-> rxd_oe && rxd_out == s.tx_shift[0])
      else $error("shift transmit does not drive receive pin");
   AST_MODE0_CLOCK_LOW: assert property ( // see (R2)
      (s.tx_state == TX_SYNC && $rose(txd)) |-> ##6 (!txd || s.tx_state == TX_IDLE))
      else $error("shift clock period is not twelve cycles");
   AST_START_BIT_ZERO: assert property ( // see (R5)
      $rose(s.tx_state == TX_SHIFT) |-> !txd)
      else $error("frame does not open with a zero start bit");
   AST_FLAG_WITH_STOP: assert property ( // see (R7)
      ($rose(s.serial_control[SC_TRANSMIT_FLAG]) && s.tx_state == TX_SHIFT) |-> txd)
      else $error("transmit flag set without stop bit on pin");
   AST_MODE0_RX_START: assert property ( // see (R4)
      $rose(s.rx_state == RX_SYNC) |-> $past(ren && !ri && mode == MODE_SHIFT))
      else $error("shift receive started without enable or with flag set");
   AST_ASYNC_NEEDS_ENABLE: assert property ( // see (R20)
      (s.rx_state == RX_IDLE && !ren) |=> s.rx_state == RX_IDLE)
      else $error("reception started with receive disabled");
   AST_FULL_FLAG_BLOCKS: assert property ( // see (R9)
      (rx_final && ri && !extended_uart_enable) |=> $stable(s.rx_buf) && (!s.ovr || $past(s.ovr)))
      else $error("buffer overwritten while receive flag set");
   AST_CHECK_BIT_FILTER: assert property ( // see (R15)
      (rx_final && sm2 && !rxd_in && !(sfr.wr && sfr.addr == ADDR_SERIAL_CONTROL))
      |=> $stable(s.rx_buf) && $stable(s.serial_control[SC_RECEIVE_FLAG]))
      else $error("frame with ninth bit clear was accepted");
   AST_ACCEPT_LATCH: assert property ( // see (R12)
      (rx_final && rx_accept) |=> s.serial_control[SC_RECEIVE_FLAG]
      && s.serial_control[SC_RECEIVED_NINTH_BIT] == $past(rxd_in) && s.rx_buf == $past(s.rx_shift[8:1]))
      else $error("accepted frame not latched");
   AST_OVERWRITE_FLAG: assert property ( // see (R23)
      (rx_final && rx_accept && ri) |=> s.ovr)
      else $error("overwrite flag missing");

   COV_UART8_RX: cover property (rx_final && rx_accept && mode == MODE_UART8);
   COV_UART9_TX: cover property ($rose(s.serial_control[SC_TRANSMIT_FLAG]) && mode == MODE_UART9_VAR);
   COV_SHIFT_RX: cover property (sync_done);
   COV_OVERWRITE: cover property ($rose(s.ovr));
endmodule

//--- sim/serial_peer.sv
// remote serial device model for the serial port bench
`timescale 1ns/10ps
module serial_peer (
   // clock
   input wire logic core_clk,
   // serial pins
   input wire logic txd,
   input wire logic rxd_out,
   input wire logic rxd_oe,
   output logic rxd_in
);
   logic [7:0] shift_in = 8'h00;
   initial rxd_in = 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   // mode 0 data taken on the rising shift clock, lsb first
   always @(posedge txd) begin
      if (rxd_oe) begin
         shift_in <= {rxd_out, shift_in[7:1]};
      end
   end
   // start, eight data lsb first, ninth, stop; line left high after
   task automatic send(input logic [8:0] v, input int len);
      logic [10:0] f;
      f = {1'b1, v, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd_in = f[i];
         repeat (len) @(posedge core_clk);
         #1;
      end
   endtask
   // waits for a start bit, then samples ten bit centres
   task automatic get(output logic [9:0] v, output bit ok);
      int n;
      n = 0;
      v = 10'h000;
      while (txd !== 1'b0 && n < 2000) begin
         @(posedge core_clk);
         n++;
      end
      ok = (n < 2000);
      repeat (8) @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
         repeat (16) @(posedge core_clk);
         v[i] = txd;
      end
   endtask
endmodule

//--- sim/serial_port_four_mode_uart_bench.sv
// self-checking bench for the four-mode serial port
`timescale 1ns/10ps
`define chk(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
   $display("mismatch %0t got %0h want %0h", $time, a, b); end end
module serial_port_four_mode_uart_bench;
   import serial_port_pkg::*;
   logic core_clk;
   logic sys_rst;
   sfr_req_t sfr;
   logic [7:0] sfr_rdata;
   logic tx_ready;
   baud_src_t baud;
   logic rxd_in, rxd_out, rxd_oe, txd, overwrite_error;
   int bad_count = 0;
   int checked = 0;
   int took = 0;
   logic [9:0] fr;
   bit ok;
   serial_port i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .sfr(sfr),
      .sfr_rdata(sfr_rdata), .tx_ready(tx_ready), .baud(baud),
      .dedicated_baud_timer_enable(1'b0), .rxd_in(rxd_in), .rxd_out(rxd_out),
      .rxd_oe(rxd_oe), .txd(txd), .overwrite_error(overwrite_error));
   serial_peer i_peer (.core_clk(core_clk), .txd(txd), .rxd_out(rxd_out),
      .rxd_oe(rxd_oe), .rxd_in(rxd_in));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (bad_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr = '{a, 1'b1, 1'b0, d};
      @(posedge core_clk);
      #1;
      sfr.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr = '{a, 1'b0, 1'b1, 8'h00};
      @(posedge core_clk);
      #1;
      sfr.rd = 1'b0;
      `chk(sfr_rdata, e)
   endtask
   task automatic frame(input logic [9:0] e);
      i_peer.get(fr, ok);
      if (!ok) begin
         bad_count++;
         summarize();
      end
      `chk(fr, e)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      sfr = '0;
      baud = '0;
      repeat (3) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      // reset values and an unmapped place
      rd(ADDR_SERIAL_CONTROL, SERIAL_CONTROL_RESET);
      rd(ADDR_SERIAL_DATA_BUFFER, DATA_BUFFER_RESET);
      rd(ADDR_POWER_AND_BAUD_DOUBLE_CONTROL, POWER_CONTROL_RESET);
      rd(ADDR_CONFIGURATION, CONFIGURATION_RESET);
      rd(8'h9a, 8'h00);
      // mode 0 transmit
      wr(ADDR_SERIAL_DATA_BUFFER, 8'h6b);
      repeat (110) @(posedge core_clk);
      `chk(i_peer.shift_in, 8'h6b)
      rd(ADDR_SERIAL_CONTROL, 8'h02);
      // mode 2 at double rate, fifo filled past full
      wr(ADDR_POWER_AND_BAUD_DOUBLE_CONTROL, 8'h80);
      wr(ADDR_SERIAL_CONTROL, 8'h98);
      fork
         for (int i = 0; i < 10; i++) begin
            if (tx_ready === 1'b1) took++;
            wr(ADDR_SERIAL_DATA_BUFFER, 8'h40 + 8'(i));
         end
         for (int i = 0; i < 9; i++) frame({2'b11, 8'h40 + 8'(i)});
      join
      `chk(took, 9)
      rd(ADDR_SERIAL_CONTROL, 8'h9a);
      wr(ADDR_SERIAL_CONTROL, 8'h98);
      // receive, then a second frame while the flag is set
      i_peer.send({1'b1, 8'h3c}, 16);
      rd(ADDR_SERIAL_CONTROL, 8'h9d);
      rd(ADDR_SERIAL_DATA_BUFFER, 8'h3c);
      i_peer.send({1'b0, 8'hc3}, 16);
      rd(ADDR_SERIAL_DATA_BUFFER, 8'h3c);
      rd(ADDR_SERIAL_CONTROL, 8'h9d);
      // address filter on the ninth bit
      wr(ADDR_SERIAL_CONTROL, 8'hb0);
      i_peer.send({1'b0, 8'h11}, 16);
      rd(ADDR_SERIAL_CONTROL, 8'hb0);
      i_peer.send({1'b1, 8'h22}, 16);
      rd(ADDR_SERIAL_CONTROL, 8'hb5);
      // extended mode overwrites and flags it
      wr(ADDR_CONFIGURATION, 8'h20);
      i_peer.send({1'b1, 8'h55}, 16);
      `chk(overwrite_error, 1'b1)
      rd(ADDR_SERIAL_DATA_BUFFER, 8'h55);
      `chk(overwrite_error, 1'b0)
      // receiver disabled
      wr(ADDR_SERIAL_CONTROL, 8'h80);
      i_peer.send({1'b1, 8'h77}, 16);
      rd(ADDR_SERIAL_CONTROL, 8'h80);
      // mode 1 on timer 1 overflow, stop bit checked
      baud.t1_ovf = 1'b1;
      wr(ADDR_SERIAL_CONTROL, 8'h70);
      fork
         wr(ADDR_SERIAL_DATA_BUFFER, 8'he1);
         frame({2'b11, 8'he1});
      join
      i_peer.send({1'b0, 8'h12}, 16);
      rd(ADDR_SERIAL_CONTROL, 8'h72);
      i_peer.send({1'b1, 8'h99}, 16);
      rd(ADDR_SERIAL_CONTROL, 8'h77);
      rd(ADDR_SERIAL_DATA_BUFFER, 8'h99);
      // mode 0 receive with the line held high
      wr(ADDR_SERIAL_CONTROL, 8'h10);
      repeat (110) @(posedge core_clk);
      rd(ADDR_SERIAL_CONTROL, 8'h11);
      rd(ADDR_SERIAL_DATA_BUFFER, 8'hff);
      summarize();
   end
endmodule
